//--- design/csc_cpu_sysconf.sv
/*
  csc_cpu_sysconf: cpu core sfr bank (system configuration, status word,
  stack top, multiply/divide control, code segment base, instruction
  pointer) and the pin-facing logic steered by the configuration register.
  assumes: sfr writes and reads come from the cpu execute stage on mclk;
  port straps are raw pins; mclk runs at twice the cpu operating rate.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - pointer and segment base not directly accessible
// - status, stack, muldiv take hardware updates
// - software write beats simultaneous hardware update
// - single-byte write zeroes the other byte
// - reserved bits ignore writes, read zero
// - configuration reset value partly from straps
// - visible bit mirrors peripheral accesses externally
// - enable bit gates on-chip peripheral access
// - chip selects latched or combinational
// - strobe config from strap, splits write strobes
// - clock output enable bit
// - byte-high pin disable from bus width
// - segmentation off saves pointer only
// - stack field selects 32 to 1024 words
// - end of init locks configuration
// - debug path still writes visible bit
// - clock out at cpu rate, 50 % duty, auto driver
module csc_cpu_sysconf #(
  parameter int CS_WIDTH = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire csc_pkg::csc_sfr_wr_type sfrWr,
  input wire logic sfrRdEn,
  input wire logic [15:0] sfrRdAddr,
  output logic [15:0] sfrRdData,
  input wire csc_pkg::csc_hw_upd_type pswUpd,
  input wire csc_pkg::csc_hw_upd_type spUpd,
  input wire csc_pkg::csc_hw_upd_type mdcUpd,
  input wire logic branchTaken,
  input wire logic branchSegment,
  input wire logic [15:0] branchTarget,
  input wire logic [7:0] branchSegTarget,
  output logic [15:0] instructionPointer,
  output logic [7:0] codeSegmentBase,
  input wire logic endOfInitInstruction,
  input wire logic debugAccessWr,
  input wire logic debugVisibleData,
  input wire logic portZeroHighBit0,
  input wire logic busWidthByte,
  input wire logic periphReq,
  output logic periphGrant,
  output logic periphMirror,
  input wire logic [CS_WIDTH-1:0] csDecode,
  input wire logic addrLatch,
  output logic [CS_WIDTH-1:0] chipSelect,
  input wire logic busWrite,
  input wire logic busLowByte,
  input wire logic busHighByte,
  output logic writeStrobePin,
  output logic highByteEnablePin,
  output logic highByteEnablePinOe,
  output logic systemClockOutPinO,
  output logic systemClockOutPinOe,
  output logic saveCodeSegment,
  output logic [10:0] stackSizeWords,
  output logic initDone
);

  // register state
  logic [15:0] sysconf_r;
  logic [15:0] sysconf_nxt;
  logic [15:0] psw_r;
  logic [15:0] psw_nxt;
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  logic [15:0] mdc_r;
  logic [15:0] mdc_nxt;
  logic [15:0] csp_r;
  logic [15:0] csp_nxt;
  logic [15:0] ip_r;
  logic [15:0] ip_nxt;
  logic initDone_r;
  logic strapLoad_r;
  logic [1:0] strapWrSync_r;
  logic [1:0] strapBwSync_r;
  logic [15:0] rdData_r;
  logic [CS_WIDTH-1:0] csLatched_r;
  logic system_clock_out_pin_r;
  logic clkOutEn_r;
  logic [7:0] clkDivCnt_r;

  // merges a byte-lane write: the unaddressed byte becomes zero
  function automatic logic [15:0] laneWrite(input logic [1:0] be, input logic [15:0] d,
                                            input logic [15:0] mask);
    logic [15:0] v;
    v = 16'h0000;
    if (be[0]) begin
      v[7:0] = d[7:0];
    end
    if (be[1]) begin
      v[15:8] = d[15:8];
    end
    laneWrite = v & mask;
  endfunction

  function automatic logic [10:0] stackWords(input logic [2:0] code);
    logic [10:0] w;
    w = CSC_STK_MAX_WORDS_F();
    if (code <= csc_pkg::CSC_STK_MAX_CODE) begin
      w = 11'(csc_pkg::CSC_STK_MIN_WORDS << code);
    end
    stackWords = w;
  endfunction

  function automatic logic [10:0] CSC_STK_MAX_WORDS_F();
    CSC_STK_MAX_WORDS_F = csc_pkg::CSC_STK_MAX_WORDS;
  endfunction

  // address decode
  wire logic anyWrite = sfrWr.en && (sfrWr.byteEn != 2'h0);
  wire logic wrSyscon = anyWrite && (sfrWr.addr == csc_pkg::CSC_ADDR_SYSTEM_CONFIGURATION);
  wire logic wrPsw = anyWrite && (sfrWr.addr == csc_pkg::CSC_ADDR_PSW);
  wire logic wrSp = anyWrite && (sfrWr.addr == csc_pkg::CSC_ADDR_SP);
  wire logic wrMdc = anyWrite && (sfrWr.addr == csc_pkg::CSC_ADDR_MDC);
  wire logic [15:0] wrSysconVal = laneWrite(sfrWr.byteEn, sfrWr.data,
                                            csc_pkg::CSC_MASK_SYSTEM_CONFIGURATION);
  wire logic [15:0] wrPswVal = laneWrite(sfrWr.byteEn, sfrWr.data, csc_pkg::CSC_MASK_PSW);
  wire logic [15:0] wrSpVal = laneWrite(sfrWr.byteEn, sfrWr.data, csc_pkg::CSC_MASK_SP);
  wire logic [15:0] wrMdcVal = laneWrite(sfrWr.byteEn, sfrWr.data, csc_pkg::CSC_MASK_MDC);

  // configuration register next value
  always_comb begin
    sysconf_nxt = sysconf_r;
    if (strapLoad_r) begin
      sysconf_nxt[csc_pkg::CSC_BIT_STROBE_CFG] = strapWrSync_r[1];
      sysconf_nxt[csc_pkg::CSC_BIT_BHE_DIS] = strapBwSync_r[1];
    end else if (wrSyscon && !initDone_r) begin
      sysconf_nxt = wrSysconVal;
    end else if (debugAccessWr) begin
      sysconf_nxt[csc_pkg::CSC_BIT_VISIBLE] = debugVisibleData;
    end
    sysconf_nxt = sysconf_nxt & csc_pkg::CSC_MASK_SYSTEM_CONFIGURATION;
  end

  // status, stack and muldiv: software first, then hardware
  always_comb begin
    psw_nxt = psw_r;
    if (wrPsw) begin
      psw_nxt = wrPswVal;
    end else if (pswUpd.en) begin
      psw_nxt = pswUpd.data & csc_pkg::CSC_MASK_PSW;
    end
  end

  always_comb begin
    sp_nxt = sp_r;
    if (wrSp) begin
      sp_nxt = wrSpVal;
    end else if (spUpd.en) begin
      sp_nxt = spUpd.data & csc_pkg::CSC_MASK_SP;
    end
  end

  always_comb begin
    mdc_nxt = mdc_r;
    if (wrMdc) begin
      mdc_nxt = wrMdcVal;
    end else if (mdcUpd.en) begin
      mdc_nxt = mdcUpd.data & csc_pkg::CSC_MASK_MDC;
    end
  end

  // pointer and segment base move only on branches, sfr writes ignored
  always_comb begin
    ip_nxt = ip_r;
    csp_nxt = csp_r;
    if (branchTaken) begin
      ip_nxt = branchTarget;
      if (branchSegment) begin
        csp_nxt = {8'h00, branchSegTarget} & csc_pkg::CSC_MASK_CSP;
      end
    end
  end

  // one short flop block per register; only constants load under reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sysconf_r <= csc_pkg::CSC_RST_SYSTEM_CONFIGURATION;
    end else begin
      sysconf_r <= sysconf_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      psw_r <= csc_pkg::CSC_RST_PSW;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp_r <= csc_pkg::CSC_RST_SP;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mdc_r <= csc_pkg::CSC_RST_MDC;
    end else begin
      mdc_r <= mdc_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      csp_r <= csc_pkg::CSC_RST_CSP;
    end else begin
      csp_r <= csp_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ip_r <= csc_pkg::CSC_RST_IP;
    end else begin
      ip_r <= ip_nxt;
    end
  end

  // straps: synchronised, then loaded in the cycle after the sync settles
  // so the async reset itself only ever loads constants
  logic [1:0] strapCnt_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strapWrSync_r <= 2'h0;
      strapBwSync_r <= 2'h0;
      strapCnt_r <= 2'h0;
      strapLoad_r <= 1'b0;
    end else begin
      strapWrSync_r <= {strapWrSync_r[0], portZeroHighBit0};
      strapBwSync_r <= {strapBwSync_r[0], busWidthByte};
      if (strapCnt_r != 2'h3) begin
        strapCnt_r <= strapCnt_r + 2'h1;
      end
      strapLoad_r <= (strapCnt_r == 2'h1);
    end
  end

  // end of init is sticky until reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      initDone_r <= 1'b0;
    end else if (endOfInitInstruction) begin
      initDone_r <= 1'b1;
    end
  end

  // read path; pointer and segment base read as zero
  wire logic [15:0] rdMux =
    (sfrRdAddr == csc_pkg::CSC_ADDR_SYSTEM_CONFIGURATION) ? (sysconf_r & csc_pkg::CSC_MASK_SYSTEM_CONFIGURATION) :
    (sfrRdAddr == csc_pkg::CSC_ADDR_PSW) ? (psw_r & csc_pkg::CSC_MASK_PSW) :
    (sfrRdAddr == csc_pkg::CSC_ADDR_SP) ? (sp_r & csc_pkg::CSC_MASK_SP) :
    (sfrRdAddr == csc_pkg::CSC_ADDR_MDC) ? (mdc_r & csc_pkg::CSC_MASK_MDC) :
    16'h0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData_r <= 16'h0000;
    end else if (sfrRdEn) begin
      rdData_r <= rdMux;
    end
  end

  // configuration fields
  wire logic cfgVisible = sysconf_r[csc_pkg::CSC_BIT_VISIBLE];
  wire logic cfgPeriphEn = sysconf_r[csc_pkg::CSC_BIT_PERIPH_EN];
  wire logic cfgCsTiming = sysconf_r[csc_pkg::CSC_BIT_CS_TIMING];
  wire logic cfgStrobe = sysconf_r[csc_pkg::CSC_BIT_STROBE_CFG];
  wire logic cfgClkEn = sysconf_r[csc_pkg::CSC_BIT_CLK_OUT_EN];
  wire logic cfgBheDis = sysconf_r[csc_pkg::CSC_BIT_BHE_DIS];
  wire logic cfgSegOff = sysconf_r[csc_pkg::CSC_BIT_SEG_OFF];
  wire logic [2:0] cfgStack = sysconf_r[csc_pkg::CSC_STK_MSB:csc_pkg::CSC_STK_LSB];

  // peripheral bus gating and mirroring
  assign periphGrant = periphReq && cfgPeriphEn;
  assign periphMirror = periphReq && cfgPeriphEn && cfgVisible;

  // chip selects: latched copy is the safe default against address glitches
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      csLatched_r <= '0;
    end else if (addrLatch) begin
      csLatched_r <= csDecode;
    end
  end
  assign chipSelect = cfgCsTiming ? csDecode : csLatched_r;

  // write strobes
  assign writeStrobePin = cfgStrobe ? (busWrite && busLowByte) : busWrite;
  assign highByteEnablePin = cfgStrobe ? (busWrite && busHighByte) : busHighByte;
  assign highByteEnablePinOe = !cfgBheDis;

  // pin driver enable trails the bit by one cycle, in step with the divider
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clkOutEn_r <= 1'b0;
    end else begin
      clkOutEn_r <= cfgClkEn;
    end
  end

  // clock out: open drain, driver only pulls low while the low half runs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      system_clock_out_pin_r <= 1'b0;
      clkDivCnt_r <= 8'h00;
    end else begin
      if (!cfgClkEn) begin
        system_clock_out_pin_r <= 1'b0;
        clkDivCnt_r <= 8'h00;
      end else if (clkDivCnt_r == 8'(csc_pkg::CSC_CLK_DIV - 1)) begin
        system_clock_out_pin_r <= !system_clock_out_pin_r;
        clkDivCnt_r <= 8'h00;
      end else begin
        clkDivCnt_r <= clkDivCnt_r + 8'h01;
      end
    end
  end
  assign systemClockOutPinO = 1'b0;
  assign systemClockOutPinOe = clkOutEn_r && !system_clock_out_pin_r;

  // interrupt frame control and stack sizing
  assign saveCodeSegment = !cfgSegOff;
  assign stackSizeWords = stackWords(cfgStack);

  assign sfrRdData = rdData_r;
  assign instructionPointer = ip_r;
  assign codeSegmentBase = csp_r[7:0];
  assign initDone = initDone_r;

endmodule

//--- design/csc_pkg.sv
/*
  csc_pkg: offsets, masks, reset values, field positions and carrier types
  for the cpu system configuration sfr block.
  assumes a 16-bit sfr space addressed by byte address, word registers.
*/
package csc_pkg;

  // sfr byte addresses
  localparam logic [15:0] CSC_ADDR_PSW = 16'hff10;
  localparam logic [15:0] CSC_ADDR_SYSTEM_CONFIGURATION = 16'hff12;
  localparam logic [15:0] CSC_ADDR_SP = 16'hfe12;
  localparam logic [15:0] CSC_ADDR_MDC = 16'hff0e;
  localparam logic [15:0] CSC_ADDR_CSP = 16'hfe08;
  localparam logic [15:0] CSC_ADDR_IP = 16'hfe0a;

  // implemented-bit masks; everything else reads zero
  localparam logic [15:0] CSC_MASK_SYSTEM_CONFIGURATION = 16'hebc6;
  localparam logic [15:0] CSC_MASK_PSW = 16'hf83f;
  localparam logic [15:0] CSC_MASK_SP = 16'hfffe;
  localparam logic [15:0] CSC_MASK_MDC = 16'h00ff;
  localparam logic [15:0] CSC_MASK_CSP = 16'h00ff;

  // reset values
  localparam logic [15:0] CSC_RST_SYSTEM_CONFIGURATION = 16'hea84;
  localparam logic [15:0] CSC_RST_PSW = 16'h0000;
  localparam logic [15:0] CSC_RST_SP = 16'hfc00;
  localparam logic [15:0] CSC_RST_MDC = 16'h0000;
  localparam logic [15:0] CSC_RST_CSP = 16'h0000;
  localparam logic [15:0] CSC_RST_IP = 16'h0000;

  // system configuration field positions
  localparam int CSC_BIT_VISIBLE = 1;
  localparam int CSC_BIT_PERIPH_EN = 2;
  localparam int CSC_BIT_CS_TIMING = 6;
  localparam int CSC_BIT_STROBE_CFG = 7;
  localparam int CSC_BIT_CLK_OUT_EN = 8;
  localparam int CSC_BIT_BHE_DIS = 9;
  localparam int CSC_BIT_SEG_OFF = 11;
  localparam int CSC_STK_LSB = 13;
  localparam int CSC_STK_MSB = 15;

  // stack size: 32 words shifted by the field code, capped at 1024
  localparam logic [10:0] CSC_STK_MIN_WORDS = 11'h020;
  localparam logic [10:0] CSC_STK_MAX_WORDS = 11'h400;
  localparam logic [2:0] CSC_STK_MAX_CODE = 3'h5;

  // clock output: toggles every mclk cycle while the enable bit is set
  localparam int CSC_CLK_DIV = 1;

  typedef struct packed {
    logic en;
    logic [1:0] byteEn;
    logic [15:0] addr;
    logic [15:0] data;
  } csc_sfr_wr_type;

  typedef struct packed {
    logic en;
    logic [15:0] data;
  } csc_hw_upd_type;

endpackage

//--- verification/csc_cpu_sysconf_assertions.sv
/*
  csc_cpu_sysconf_assertions: port-level checker for the cpu sfr bank.
  assumes one clock domain (mclk) and async active-high rst.
*/
`timescale 1ns/1ps
module csc_cpu_sysconf_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic periphReq,
  input wire logic periphGrant,
  input wire logic periphMirror,
  input wire logic branchTaken,
  input wire logic branchSegment,
  input wire logic [15:0] branchTarget,
  input wire logic [15:0] instructionPointer,
  input wire logic [7:0] codeSegmentBase,
  input wire logic endOfInitInstruction,
  input wire logic initDone,
  input wire logic [10:0] stackSizeWords,
  input wire logic systemClockOutPinOe,
  input wire logic busWrite,
  input wire logic writeStrobePin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_mirror; periphMirror |-> periphGrant; endproperty
  a_mirror: assert property (p_mirror) else $error("mirror without grant");
  property p_grant; periphGrant |-> periphReq; endproperty
  a_grant: assert property (p_grant) else $error("grant without request");
  property p_ipHold; !branchTaken |=> $stable(instructionPointer); endproperty
  a_ipHold: assert property (p_ipHold) else $error("pointer moved");
  property p_ipLoad; branchTaken |=> instructionPointer == $past(branchTarget); endproperty
  a_ipLoad: assert property (p_ipLoad) else $error("pointer not loaded");
  property p_cspHold; !(branchTaken && branchSegment) |=> $stable(codeSegmentBase); endproperty
  a_cspHold: assert property (p_cspHold) else $error("segment base moved");
  property p_initSet; endOfInitInstruction |=> initDone [*3]; endproperty
  a_initSet: assert property (p_initSet) else $error("init lock missing");
  property p_stack; $onehot(stackSizeWords) && stackSizeWords >= 11'h020; endproperty
  a_stack: assert property (p_stack) else $error("stack size out of range");
  property p_clkDuty; systemClockOutPinOe |=> !systemClockOutPinOe; endproperty
  a_clkDuty: assert property (p_clkDuty) else $error("clock out duty wrong");
  property p_strobe; !busWrite |-> !writeStrobePin; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without write");

  c_branch: cover property (branchTaken && branchSegment);
  c_init: cover property (initDone);
  c_clk: cover property (systemClockOutPinOe);
endmodule

bind csc_cpu_sysconf csc_cpu_sysconf_assertions i_chk (.mclk, .rst, .periphReq, .periphGrant,
  .periphMirror, .branchTaken, .branchSegment, .branchTarget, .instructionPointer,
  .codeSegmentBase, .endOfInitInstruction, .initDone, .stackSizeWords,
  .systemClockOutPinOe, .busWrite, .writeStrobePin);

//--- verification/csc_cpu_sysconf_tb.sv
/*
  csc_cpu_sysconf_tb: self-checking bench for the cpu sfr bank.
  assumes the checker binds itself; straps start high to match ea84,
  then go low across a second reset.
*/
`timescale 1ns/1ps
module csc_cpu_sysconf_tb;
  logic mclk, rst, sfrRdEn, branchTaken, branchSegment, endOfInitInstruction;
  logic debugAccessWr, debugVisibleData, periphReq, addrLatch, busWrite;
  logic busLowByte, busHighByte, periphGrant, periphMirror, writeStrobePin;
  logic highByteEnablePin, highByteEnablePinOe, systemClockOutPinO;
  logic systemClockOutPinOe, saveCodeSegment, initDone;
  logic portZeroHighBit0, busWidthByte;
  logic [15:0] sfrRdAddr, sfrRdData, branchTarget, instructionPointer;
  logic [7:0] branchSegTarget, codeSegmentBase;
  logic [4:0] csDecode, chipSelect;
  logic [10:0] stackSizeWords;
  csc_pkg::csc_sfr_wr_type sfrWr;
  csc_pkg::csc_hw_upd_type pswUpd, spUpd, mdcUpd;
  int error_cnt = 0;
  int total_checks = 0;
  int n;

  csc_cpu_sysconf i_dut (.mclk, .rst, .sfrWr, .sfrRdEn, .sfrRdAddr, .sfrRdData, .pswUpd,
    .spUpd, .mdcUpd, .branchTaken, .branchSegment, .branchTarget, .branchSegTarget,
    .instructionPointer, .codeSegmentBase, .endOfInitInstruction, .debugAccessWr,
    .debugVisibleData, .portZeroHighBit0, .busWidthByte, .periphReq,
    .periphGrant, .periphMirror, .csDecode, .addrLatch, .chipSelect, .busWrite,
    .busLowByte, .busHighByte, .writeStrobePin, .highByteEnablePin, .highByteEnablePinOe,
    .systemClockOutPinO, .systemClockOutPinOe, .saveCodeSegment, .stackSizeWords, .initDone);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge mclk) sfrWr = '{1'b1, be, a, d};
    @(negedge mclk) sfrWr = '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge mclk);
    sfrRdEn = 1'b1;
    sfrRdAddr = a;
    @(negedge mclk) sfrRdEn = 1'b0;
    chk(sfrRdData, e);
  endtask

  task automatic t_bytes;
    rd(16'hff12, 16'hea84);
    rd(16'hfe12, 16'hfc00);
    wr(16'hff12, 2'b01, 16'h12c6);
    rd(16'hff12, 16'h00c6);
    wr(16'hff12, 2'b10, 16'hffff);
    rd(16'hff12, 16'heb00);
    wr(16'hff12, 2'b11, 16'hffff);
    rd(16'hff12, 16'hebc6);
  endtask

  task automatic t_pins;
    periphReq = 1'b1;
    busWrite = 1'b1;
    busHighByte = 1'b1;
    csDecode = 5'h15;
    @(negedge mclk);
    chk(16'(periphMirror), 16'h1);
    chk(16'(periphGrant), 16'h1);
    chk(16'(saveCodeSegment), 16'h0);
    chk(16'(highByteEnablePinOe), 16'h0);
    chk(16'(stackSizeWords), 16'h0400);
    chk(16'(writeStrobePin), 16'h0);
    chk(16'(highByteEnablePin), 16'h1);
    chk(16'(chipSelect), 16'h0015);
    wr(16'hff12, 2'b11, 16'h0000);
    csDecode = 5'h0a;
    addrLatch = 1'b1;
    @(negedge mclk);
    addrLatch = 1'b0;
    csDecode = 5'h1f;
    @(negedge mclk);
    chk(16'(chipSelect), 16'h000a);
    chk(16'(periphGrant), 16'h0);
    chk(16'(saveCodeSegment), 16'h1);
    chk(16'(highByteEnablePinOe), 16'h1);
    chk(16'(stackSizeWords), 16'h0020);
    chk(16'(writeStrobePin), 16'h1);
  endtask

  task automatic t_clock;
    wr(16'hff12, 2'b11, 16'h0100);
    repeat (3) @(negedge mclk);
    n = 0;
    // a pin period is two mclk cycles, so eight cycles hold four lows
    repeat (8) begin
      @(negedge mclk);
      n += int'(systemClockOutPinOe === 1'b1);
    end
    chk(16'(n), 16'h0004);
    chk(16'(systemClockOutPinO), 16'h0);
  endtask

  task automatic t_hw;
    @(negedge mclk);
    pswUpd = '{1'b1, 16'hffff};
    sfrWr = '{1'b1, 2'b11, 16'hff10, 16'h0001};
    @(negedge mclk);
    pswUpd = '0;
    sfrWr = '0;
    rd(16'hff10, 16'h0001);
    @(negedge mclk) pswUpd = '{1'b1, 16'hffff};
    @(negedge mclk) pswUpd = '0;
    rd(16'hff10, 16'hf83f);
    @(negedge mclk);
    spUpd = '{1'b1, 16'h1111};
    sfrWr = '{1'b1, 2'b10, 16'hfe12, 16'h5aa5};
    @(negedge mclk);
    spUpd = '0;
    sfrWr = '0;
    rd(16'hfe12, 16'h5a00);
    @(negedge mclk) mdcUpd = '{1'b1, 16'hffff};
    @(negedge mclk) mdcUpd = '0;
    rd(16'hff0e, 16'h00ff);
  endtask

  task automatic t_straps;
    @(negedge mclk);
    portZeroHighBit0 = 1'b0;
    busWidthByte = 1'b0;
    busWrite = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk(16'(initDone), 16'h0);
    repeat (4) @(negedge mclk);
    rd(16'hff12, 16'he804);
    chk(16'(highByteEnablePinOe), 16'h1);
    chk(16'(highByteEnablePin), 16'h1);
    chk(16'(writeStrobePin), 16'h0);
  endtask

  task automatic t_pointer;
    wr(16'hfe0a, 2'b11, 16'h1234);
    rd(16'hfe0a, 16'h0000);
    chk(instructionPointer, 16'h0000);
    @(negedge mclk);
    branchTaken = 1'b1;
    branchSegment = 1'b1;
    branchTarget = 16'h1234;
    branchSegTarget = 8'h56;
    @(negedge mclk);
    branchTaken = 1'b0;
    branchSegment = 1'b0;
    chk(instructionPointer, 16'h1234);
    chk(16'(codeSegmentBase), 16'h0056);
  endtask

  task automatic t_init;
    wr(16'hff12, 2'b11, 16'h0002);
    @(negedge mclk) endOfInitInstruction = 1'b1;
    @(negedge mclk) endOfInitInstruction = 1'b0;
    wr(16'hff12, 2'b11, 16'h0004);
    rd(16'hff12, 16'h0002);
    @(negedge mclk) debugAccessWr = 1'b1;
    @(negedge mclk) debugAccessWr = 1'b0;
    rd(16'hff12, 16'h0000);
  endtask

  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    sfrWr = '0;
    pswUpd = '0;
    spUpd = '0;
    mdcUpd = '0;
    {sfrRdEn, branchTaken, branchSegment, endOfInitInstruction} = 4'h0;
    {debugAccessWr, debugVisibleData, periphReq, addrLatch} = 4'h0;
    {busWrite, busLowByte, busHighByte} = 3'h0;
    {portZeroHighBit0, busWidthByte} = 2'h3;
    sfrRdAddr = 16'h0000;
    branchTarget = 16'h0000;
    branchSegTarget = 8'h00;
    csDecode = 5'h00;
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    // straps settle three edges after release
    repeat (4) @(negedge mclk);
    t_bytes();
    t_pins();
    t_clock();
    t_hw();
    t_pointer();
    t_init();
    t_straps();
    summarize();
  end
endmodule
